// ### rtl/and_branch_bitclear_exec.sv
// Executor for the accumulator-AND-file, branch-on-carry and
// bit-clear-file instructions of an 8-bit core.
// Assumes the fetch path presents a word with instrValid and holds it
// until instrTaken; all logic sits on one clock with a clock enable.
//
// Functional notes
// RQ1 - AND-file: top six bits 000101, bit9 dest, bit8 bank, low byte file.
// RQ2 - AND accumulator with file; dest 0 to accumulator, 1 to file.
// RQ3 - AND-file sets only negative and zero flags from the result.
// RQ4 - Bank bit 0 uses access bank; 1 uses bank select register.
// RQ5 - Extended set, bank bit 0, file at most 95: indexed offset address.
// RQ6 - Branch-on-carry: upper byte 11100010, lower byte signed offset.
// RQ7 - Carry set: PC gets instruction address plus 2 plus twice offset.
// RQ8 - Target relative to incremented PC; doubled offset keeps words even.
// RQ9 - Branch is one word; one cycle, or two when taken, second idle.
// RQ10 - Branch and bit-clear leave every status flag alone.
// RQ11 - Bit-clear: nibble 1001, bit index, bank bit, file; clears that bit.
// RQ12 - AND and bit-clear: decode, read, process, write in four phases.
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/10ps
module and_branch_bitclear_exec
  import exec_pkg::*;
#(
  parameter int PC_W   = 21,
  parameter int BANK_W = 4
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              clkEn,
  input  wire logic              instrValid,
  input  wire logic [WORD_W-1:0] instrWord,
  input  wire logic [3:0]        busAddr,
  input  wire logic [31:0]       busWrData,
  input  wire logic              busWr,
  input  wire logic              busRd,
  output logic      [31:0]       busRdData,
  output logic                   instrTaken,
  output logic      [PC_W-1:0]   pcOut,
  output phase_t                 phaseOut,
  output logic                   stallOut
);

  localparam int AW = BANK_W + 8;

  ////////////////////////////////////////////////////////////////////////
  // State
  phase_t          phase_reg;
  phase_t          phase_next;
  logic            nop_reg;
  logic            taken_reg;
  logic [PC_W-1:0] pc_reg;
  logic [7:0]      accum_reg;
  logic [4:0]      status_reg;
  logic [7:0]      bank_reg;
  logic [AW-1:0]   index_reg;
  logic            ext_reg;
  logic [31:0]     rdOut_reg;
  logic            curAnd_reg;
  logic            curBc_reg;
  logic            curBcf_reg;
  logic            curDest_reg;
  logic            curBank_reg;
  logic [2:0]      curBit_reg;
  logic [7:0]      curFile_reg;
  logic [7:0]      result_reg;
  logic [AW-1:0]   memAddr_reg;

  ////////////////////////////////////////////////////////////////////////
  // Decode of the presented word
  wire        isAnd  = instrWord[OP6_MSB:OP6_LSB] == OP_AND_CODE; // [RQ1]
  wire        isBc   = instrWord[OP8_MSB:OP8_LSB] == OP_BC_CODE;  // [RQ6]
  wire        isBcf  = instrWord[OP4_MSB:OP4_LSB] == OP_BCF_CODE; // [RQ11]
  wire        take   = clkEn && phase_reg == PH_DECODE && instrValid
                       && !nop_reg;
  wire [7:0]  offset = curFile_reg;  // Branch offset shares the low byte

  ////////////////////////////////////////////////////////////////////////
  // Operand address for the byte and bit file forms
  function automatic logic [AW-1:0] fileAddr(
    input logic          bankMode,
    input logic [7:0]    file,
    input logic [7:0]    bank,
    input logic          ext,
    input logic [AW-1:0] index
  );
    logic [AW-1:0] a;
    a = {{BANK_W{1'b0}}, file};
    if (bankMode)
      a = {bank[BANK_W-1:0], file};                          // [RQ4]
    else if (ext && file <= INDEX_LIMIT)
      a = index + {{BANK_W{1'b0}}, file};                    // [RQ5]
    else if (file >= ACCESS_SPLIT)
      a = {{BANK_W{1'b1}}, file};                            // [RQ4]
    return a;
  endfunction

  wire [AW-1:0] operandAddr = fileAddr(curBank_reg, curFile_reg, bank_reg,
                                       ext_reg, index_reg);

  ////////////////////////////////////////////////////////////////////////
  // Memory port: read in the read phase, write in the write phase
  wire       memRd   = phase_reg == PH_READ && !nop_reg
                       && (curAnd_reg || curBcf_reg);             // [RQ12]
  wire       memWr   = phase_reg == PH_WRITE && !nop_reg
                       && (curBcf_reg || (curAnd_reg && curDest_reg));
  wire [AW-1:0] memAddrSel = memRd ? operandAddr : memAddr_reg;
  wire [7:0] memRdData;

  data_ram #(
    .AW (AW),
    .DW (8)
  ) u_ram (
    .clock  (clock),
    .clkEn  (clkEn),
    .rdEn   (memRd),
    .wrEn   (memWr),
    .addr   (memAddrSel),
    .wrData (result_reg),
    .rdData (memRdData)
  );

  ////////////////////////////////////////////////////////////////////////
  // Data path: the AND result and the bit-clear result
  wire [7:0] bitMask   = 8'h01 << curBit_reg;
  wire [7:0] andResult = accum_reg & memRdData;                  // [RQ2]
  wire [7:0] bcfResult = memRdData & ~bitMask;                   // [RQ11]
  wire [7:0] procNext  = curAnd_reg ? andResult : bcfResult;

  ////////////////////////////////////////////////////////////////////////
  // Branch target from the incremented PC, offset doubled
  wire [PC_W-1:0] pcPlus2   = pc_reg + PC_W'(2);                 // [RQ8]
  wire [PC_W-1:0] offDouble = {{(PC_W-9){offset[7]}}, offset, 1'b0};
  wire [PC_W-1:0] pcTarget  = pcPlus2 + offDouble;               // [RQ7]
  wire            bcTaken   = curBc_reg && status_reg[FLG_C];
  wire            lastPhase = phase_reg == PH_WRITE;
  wire            execEnd   = lastPhase && !nop_reg && taken_reg;

  ////////////////////////////////////////////////////////////////////////
  // Phase rotation: every instruction cycle has four phases
  always_comb
  begin
    case (phase_reg)
      PH_DECODE:  phase_next = PH_READ;
      PH_READ:    phase_next = PH_PROCESS;
      PH_PROCESS: phase_next = PH_WRITE;
      PH_WRITE:   phase_next = PH_DECODE;
      default:    phase_next = PH_DECODE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer, decode latch and idle cycle after a taken branch
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      phase_reg   <= PH_DECODE;
      nop_reg     <= 1'b0;
      taken_reg   <= 1'b0;
      curAnd_reg  <= 1'b0;
      curBc_reg   <= 1'b0;
      curBcf_reg  <= 1'b0;
      curDest_reg <= 1'b0;
      curBank_reg <= 1'b0;
      curBit_reg  <= 3'h0;
      curFile_reg <= 8'h00;
      instrTaken  <= 1'b0;
    end
    else if (clkEn)
    begin
      phase_reg  <= phase_next;                                  // [RQ12]
      instrTaken <= take;
      if (phase_reg == PH_DECODE)
      begin
        taken_reg   <= take;
        curAnd_reg  <= take && isAnd;
        curBc_reg   <= take && isBc;
        curBcf_reg  <= take && isBcf;
        curDest_reg <= instrWord[DEST_BIT];
        curBank_reg <= instrWord[BANKM_BIT];
        curBit_reg  <= instrWord[BIDX_MSB:BIDX_LSB];
        curFile_reg <= instrWord[FADR_MSB:FADR_LSB];
      end
      // A taken branch spends one whole further cycle doing nothing
      if (execEnd && bcTaken)
        nop_reg <= 1'b1;                                         // [RQ9]
      else if (lastPhase)
        nop_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Operand address and result registers
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      memAddr_reg <= '0;
      result_reg  <= 8'h00;
    end
    else if (clkEn)
    begin
      if (memRd)
        memAddr_reg <= operandAddr;
      if (phase_reg == PH_PROCESS)
        result_reg <= procNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes; the core's write phase wins over a software write
  // in the same cycle so that no result is lost
  wire swAccum  = busWr && busAddr == REG_ACCUM;
  wire swStatus = busWr && busAddr == REG_STATUS;
  wire swPc     = busWr && busAddr == REG_PC;
  wire hwAccum  = execEnd && curAnd_reg && !curDest_reg;         // [RQ2]
  wire hwFlags  = execEnd && curAnd_reg;                         // [RQ3]

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      accum_reg  <= ACCUM_RST;
      status_reg <= STATUS_RST;
      bank_reg   <= BANKSEL_RST;
      index_reg  <= '0;
      ext_reg    <= 1'b0;
      pc_reg     <= '0;
    end
    else if (clkEn)
    begin
      if (hwAccum)
        accum_reg <= result_reg;
      else if (swAccum)
        accum_reg <= busWrData[7:0];
      if (hwFlags)
      begin
        status_reg[FLG_N] <= result_reg[7];                      // [RQ3]
        status_reg[FLG_Z] <= result_reg == 8'h00;                // [RQ3]
      end
      else if (swStatus)
        status_reg <= busWrData[STATUS_W-1:0];                   // [RQ10]
      if (busWr && busAddr == REG_BANKSEL)
        bank_reg <= busWrData[7:0];
      if (busWr && busAddr == REG_INDEX)
        index_reg <= busWrData[AW-1:0];
      if (busWr && busAddr == REG_CTRL)
        ext_reg <= busWrData[CTRL_EXT_BIT];
      if (execEnd)
        pc_reg <= bcTaken ? pcTarget : pcPlus2;                  // [RQ7]
      else if (swPc)
        pc_reg <= {busWrData[PC_W-1:1], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port: data one cycle after the strobe, zero for unmapped words
  wire [31:0] rdSel =
    busAddr == REG_ACCUM   ? {24'h000000, accum_reg} :
    busAddr == REG_STATUS  ? {27'h0000000, status_reg} :
    busAddr == REG_BANKSEL ? {24'h000000, bank_reg} :
    busAddr == REG_INDEX   ? {{(32-AW){1'b0}}, index_reg} :
    busAddr == REG_PC      ? {{(32-PC_W){1'b0}}, pc_reg} :
    busAddr == REG_CTRL    ? {31'h00000000, ext_reg} : 32'h00000000;

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      rdOut_reg <= 32'h00000000;
    else if (clkEn)
      rdOut_reg <= busRd ? rdSel : 32'h00000000;
  end

  assign busRdData = rdOut_reg;
  assign pcOut     = pc_reg;
  assign phaseOut  = phase_reg;
  assign stallOut  = nop_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks, sampled only on enabled clock edges
  default clocking cb @(posedge clock iff clkEn);
  endclocking
  default disable iff (!rst_n);

  sequence s_branchTaken;
    execEnd && bcTaken;
  endsequence

  sequence s_idleCycle;
    nop_reg && !instrTaken;
  endsequence

  a_phase_rotate: assert property ( // [RQ12]
    phase_reg == PH_DECODE |=> phase_reg == PH_READ ##1
    phase_reg == PH_PROCESS ##1 phase_reg == PH_WRITE)
    else $error("phase sequence broken");

  a_and_decode: assert property ( // [RQ1]
    take && instrWord[OP6_MSB:OP6_LSB] == OP_AND_CODE |=> curAnd_reg
    && curDest_reg == $past(instrWord[DEST_BIT]))
    else $error("and decode wrong");

  a_and_result: assert property ( // [RQ2]
    phase_reg == PH_PROCESS && curAnd_reg |=>
    result_reg == ($past(accum_reg) & $past(memRdData)))
    else $error("and result wrong");

  a_and_flags: assert property ( // [RQ3]
    hwFlags |=> status_reg[FLG_Z] == ($past(result_reg) == 8'h00)
    && status_reg[FLG_C] == $past(status_reg[FLG_C])
    && status_reg[FLG_OV] == $past(status_reg[FLG_OV]))
    else $error("and flags wrong");

  a_index_addr: assert property ( // [RQ5]
    memRd && !curBank_reg && ext_reg && curFile_reg <= INDEX_LIMIT |=>
    memAddr_reg == $past(index_reg) + AW'($past(curFile_reg)))
    else $error("indexed address wrong");

  a_bank_addr: assert property ( // [RQ4]
    memRd && curBank_reg |=>
    memAddr_reg == {$past(bank_reg[BANK_W-1:0]), $past(curFile_reg)})
    else $error("banked address wrong");

  a_branch_target: assert property ( // [RQ7]
    s_branchTaken |=> pc_reg == $past(pcTarget)
    && pc_reg[0] == 1'b0)
    else $error("branch target wrong");

  a_branch_stall: assert property ( // [RQ9]
    s_branchTaken |=> s_idleCycle [*4] ##1 !nop_reg)
    else $error("taken branch idle cycle wrong");

  a_noflag_ops: assert property ( // [RQ10]
    execEnd && (curBc_reg || curBcf_reg) && !swStatus |=>
    $stable(status_reg))
    else $error("flags changed by branch or bit clear");

  // Case equality on the kept bits: a byte never written before holds
  // unknowns, and those must pass through the clear untouched
  a_bcf_write: assert property ( // [RQ11]
    memWr && curBcf_reg |-> result_reg[curBit_reg] == 1'b0
    && (result_reg | bitMask) === (memRdData | bitMask))
    else $error("bit clear result wrong");

  a_no_branch: assert property ( // [RQ7]
    execEnd && curBc_reg && !status_reg[FLG_C] |=>
    pc_reg == $past(pcPlus2) && !nop_reg)
    else $error("untaken branch wrong");

endmodule

// ### rtl/exec_pkg.sv
// Constants shared by the instruction executor and its self-checking bench.
// Assumes a core built around 8-bit data and 16-bit instruction words.
package exec_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Instruction word fields
  localparam int          WORD_W       = 16;
  localparam int          OP6_MSB      = 15;
  localparam int          OP6_LSB      = 10;
  localparam logic [5:0]  OP_AND_CODE  = 6'h05;  // 000101
  localparam int          OP8_MSB      = 15;
  localparam int          OP8_LSB      = 8;
  localparam logic [7:0]  OP_BC_CODE   = 8'hE2;  // 1110 0010
  localparam int          OP4_MSB      = 15;
  localparam int          OP4_LSB      = 12;
  localparam logic [3:0]  OP_BCF_CODE  = 4'h9;   // 1001
  localparam int          DEST_BIT     = 9;
  localparam int          BANKM_BIT    = 8;
  localparam int          BIDX_MSB     = 11;
  localparam int          BIDX_LSB     = 9;
  localparam int          FADR_MSB     = 7;
  localparam int          FADR_LSB     = 0;

  ////////////////////////////////////////////////////////////////////////
  // Addressing
  localparam logic [7:0]  INDEX_LIMIT  = 8'h5F;  // Highest indexed offset
  localparam logic [7:0]  ACCESS_SPLIT = 8'h80;  // Low half / high half

  ////////////////////////////////////////////////////////////////////////
  // Status flag positions
  localparam int          FLG_C        = 0;
  localparam int          FLG_DC       = 1;
  localparam int          FLG_Z        = 2;
  localparam int          FLG_OV       = 3;
  localparam int          FLG_N        = 4;
  localparam int          STATUS_W     = 5;

  ////////////////////////////////////////////////////////////////////////
  // Register port map (word indices) and reset values
  localparam logic [3:0]  REG_ACCUM    = 4'h0;
  localparam logic [3:0]  REG_STATUS   = 4'h1;
  localparam logic [3:0]  REG_BANKSEL  = 4'h2;
  localparam logic [3:0]  REG_INDEX    = 4'h3;
  localparam logic [3:0]  REG_PC       = 4'h4;
  localparam logic [3:0]  REG_CTRL     = 4'h5;
  localparam int          CTRL_EXT_BIT = 0;
  localparam logic [7:0]  ACCUM_RST    = 8'h00;
  localparam logic [4:0]  STATUS_RST   = 5'h00;
  localparam logic [7:0]  BANKSEL_RST  = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // Four-phase instruction cycle, one-hot
  typedef enum logic [3:0] {
    PH_DECODE  = 4'b0001,
    PH_READ    = 4'b0010,
    PH_PROCESS = 4'b0100,
    PH_WRITE   = 4'b1000
  } phase_t;

endpackage

// ### rtl/data_ram.sv
// Single-port data memory holding the file registers.
// Assumes one access per cycle; read data come out of a register.
`timescale 1ns/10ps
module data_ram #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  input  wire logic          clock,
  input  wire logic          clkEn,
  input  wire logic          rdEn,
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wrData,
  output logic      [DW-1:0] rdData
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  ////////////////////////////////////////////////////////////////////////
  // Read data hold their value until the next read, so the executor can
  // look at them across several phases
  always_ff @(posedge clock)
  begin
    if (clkEn && wrEn)
      mem[addr] <= wrData;
    if (clkEn && rdEn)
      rdData <= mem[addr];
  end

endmodule

// ### tb/tb_top.sv
// Self-checking bench for the AND-file, branch-on-carry and bit-clear
// executor. Assumes the design package and the data memory are compiled.
`timescale 1ns/10ps
module tb_top import exec_pkg::*;;

  ////////////////////////////////////////////////////////////////////////
  // Stimulus and observed signals
  logic        clock = 1'h0;
  logic        rst_n = 1'h0;
  logic        clkEn = 1'h1;
  logic        instrValid = 1'h0;
  logic [15:0] instrWord = 16'h0000;
  logic [3:0]  busAddr = 4'h0;
  logic [31:0] busWrData = 32'h0;
  logic        busWr = 1'h0;
  logic        busRd = 1'h0;
  logic [31:0] busRdData;
  logic        instrTaken;
  logic [20:0] pcOut;
  phase_t      phaseOut;
  logic        stallOut;
  int          errTotal = 0;
  int          nTests = 0;
  int          cycles = 0;
  logic [31:0] seed = 32'h125A9EF9;
  int          acc;
  int          st;
  int          pc;

  // Free-running 100 MHz clock
  always #5 clock = ~clock;

  and_branch_bitclear_exec and_branch_bitclear_exec_inst (
    .clock      (clock),
    .rst_n      (rst_n),
    .clkEn      (clkEn),
    .instrValid (instrValid),
    .instrWord  (instrWord),
    .busAddr    (busAddr),
    .busWrData  (busWrData),
    .busWr      (busWr),
    .busRd      (busRd),
    .busRdData  (busRdData),
    .instrTaken (instrTaken),
    .pcOut      (pcOut),
    .phaseOut   (phaseOut),
    .stallOut   (stallOut)
  );

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %h seen %h", name, exp, seen);
      errTotal++;
    end
  endtask

  // Bus tasks start and end just after a rising edge; a spare edge after
  // each strobe keeps a strobe from being assigned twice in one step
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    busWr <= 1'h1;
    busAddr <= a;
    busWrData <= d;
    @(posedge clock);
    busWr <= 1'h0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    busRd <= 1'h1;
    busAddr <= a;
    @(posedge clock);
    busRd <= 1'h0;
    @(negedge clock);
    d = busRdData;
    @(posedge clock);
  endtask

  task automatic rdchk(input logic [3:0] a, input int exp);
    logic [31:0] v;
    rd(a, v);
    chk("register read", v, 32'(exp));
  endtask

  // Offer one word, hold it until taken, then time the instruction
  task automatic exec(input logic [15:0] w, input bit jump);
    int n;
    int s;
    n = 0;
    s = 0;
    instrValid <= 1'h1;
    instrWord <= w;
    do
    begin
      @(negedge clock);
      n++;
    end while (instrTaken !== 1'h1 && n < 20);
    chk("taken", {31'h0, instrTaken}, 32'h1);
    chk("phase", {28'h0, phaseOut}, {28'h0, PH_READ});
    @(posedge clock);
    instrValid <= 1'h0;
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
      if (stallOut === 1'h1)
        s++;
    end while (!(phaseOut === PH_DECODE && stallOut === 1'h0) && n < 20);
    chk("cycles", 32'(n), jump ? 32'h7 : 32'h3);
    chk("idle cycles", 32'(s), jump ? 32'h4 : 32'h0);
    @(posedge clock);
  endtask

  // Compare architectural state with the bench model
  task automatic state();
    rdchk(REG_ACCUM, acc);
    rdchk(REG_STATUS, st);
    rdchk(REG_PC, pc);
    // Look at the port away from the launching edge
    @(negedge clock);
    chk("pc port", {11'h0, pcOut}, 32'(pc));
    @(posedge clock);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Hang guard, far above the fewer than a thousand cycles the run needs
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errTotal++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    int          i;
    int          f;
    int          e;
    int          cb;
    int          fc;
    int          ix;
    int          n8;
    bit          c;
    logic [31:0] v;
    logic [31:0] r;
    int          mask [6];
    mask = '{32'hFF, 32'h1F, 32'hFF, 32'hFFF, 32'h1FFFFE, 32'h1};
    repeat (11) @(posedge clock);
    // Outputs sit at their reset values while reset is held
    @(negedge clock);
    chk("reset phase", {28'h0, phaseOut}, {28'h0, PH_DECODE});
    chk("reset stall", {31'h0, stallOut}, 32'h0);
    chk("reset pc", {11'h0, pcOut}, 32'h0);
    chk("reset taken", {31'h0, instrTaken}, 32'h0);
    chk("reset read data", busRdData, 32'h0);
    @(posedge clock);
    rst_n <= 1'h1;
    @(posedge clock);
    // Every index, mapped or not, reads zero out of reset
    for (i = 0; i < 16; i++)
      rdchk(4'(i), 0);
    // Round trip through every register; narrow ones keep low bits only
    for (i = 0; i < 16; i++)
    begin
      v = rnd();
      wr(4'(i), v);
      rd(4'(i), r);
      chk("round trip", r, i < 6 ? v & mask[i] : 32'h0);
    end
    // A write with the clock enable low must be lost
    wr(REG_ACCUM, 32'h5A);
    clkEn <= 1'h0;
    wr(REG_ACCUM, 32'hA5);
    clkEn <= 1'h1;
    rdchk(REG_ACCUM, 32'h5A);
    acc = 32'h5A;
    pc = int'(rnd() & 32'h1FFFFE);
    wr(REG_PC, 32'(pc));
    // Branch on carry, both offset extremes first, then random
    for (i = 0; i < 8; i++)
    begin
      n8 = i == 0 ? 8'h80 : i == 1 ? 8'h7F : int'(rnd() & 32'hFF);
      c = i < 2 ? 1'b1 : i == 2 ? 1'b0 : rnd() & 1;
      st = int'(rnd() & 32'h1E) | c;
      wr(REG_STATUS, 32'(st));
      exec({OP_BC_CODE, 8'(n8)}, c);
      pc = c ? pc + 2 + 2 * int'($signed(8'(n8))) : pc + 2;
      pc = pc & 32'h1FFFFF;
      state();
    end
    // Addressing modes: clear a byte through the bank select register,
    // then reach it another way; a wrong address reads unknown memory
    for (i = 0; i < 4; i++)
    begin
      e = i > 1;
      f = i == 0 ? rnd() & 32'h7F : i == 1 ? 32'h80 | rnd() :
          i == 2 ? rnd() % 96 : 32'h60 + rnd() % 32;
      f = f & 32'hFF;
      ix = int'(rnd() & 32'hFFF);
      fc = i == 2 ? (ix + f) & 32'hFFF : (i == 1 ? 32'hF00 | f : f);
      cb = fc >> 8;
      wr(REG_CTRL, 32'(e));
      wr(REG_INDEX, 32'(ix));
      wr(REG_BANKSEL, 32'(cb));
      st = int'(rnd() & 32'h1F);
      wr(REG_STATUS, 32'(st));
      for (n8 = 0; n8 < 8; n8++)
      begin
        exec({OP_BCF_CODE, 3'(n8), 1'b1, 8'(fc)}, 1'b0);
        pc = (pc + 2) & 32'h1FFFFF;
      end
      state();
      wr(REG_BANKSEL, 32'(cb ^ 1));
      acc = int'(rnd() & 32'hFF);
      wr(REG_ACCUM, 32'(acc));
      // Result back to the file: accumulator stays, only N and Z move
      exec({OP_AND_CODE, 1'b1, 1'b0, 8'(f)}, 1'b0);
      pc = (pc + 2) & 32'h1FFFFF;
      st = (st & ~(1 << FLG_N)) | (1 << FLG_Z);
      state();
      // Result to the accumulator from the byte just rewritten
      exec({OP_AND_CODE, 1'b0, 1'b0, 8'(f)}, 1'b0);
      pc = (pc + 2) & 32'h1FFFFF;
      acc = 0;
      state();
    end
    results();
  end

endmodule
